// File: gpio_port.sv
// gpio_port: one general purpose port, per-pin driver, pull and sense logic
// assumes configuration arrives as plain ports and pads resolve the enables
`timescale 1ns/100ps

//Contract
// - up to eight pins, each individually configured
// - direction bit one output, zero input
// - push-pull output drives output value bit
// - input value readable unless input disabled
// - reset tri-states every pin, clock not needed
// - one flip-flop then input register synchronise
// - push-pull pulls active only while input
// - push-pull input without pull floats
// - bus-keeper active in both directions
// - keeper holds last seen logic level
// - wired-or drives high, releases on zero
// - wired-and drives low, releases on one
// - wired modes keep pulls in both directions
// - per-pin inversion of input and output
// - sense rising, falling, both edges, low level
// - sense raises interrupt request, event, or both
// - synchronous sensing clocked, asynchronous needs none
// - hardware read-modify-write on single direction bits
// - toggle register inverts bits, reads direction
// - edge request only after clock sampled change
module gpio_port #(
    parameter int PINS = gpio_pkg::PIN_COUNT      // number of pins, at most eight
) (
    input  wire logic                  core_clk,          // peripheral clock
    input  wire logic                  reset,             // synchronous, active high
    input  wire logic                  dirWriteEn,        // whole direction register write
    input  wire logic [PINS-1:0]       dirWriteData,      // value for direction write
    input  wire logic                  dirSetEn,          // direction_set_reg write strobe
    input  wire logic [PINS-1:0]       dirSetData,        // ones set direction bits
    input  wire logic                  dirClrEn,          // direction_clear_reg write strobe
    input  wire logic [PINS-1:0]       dirClrData,        // ones clear direction bits
    input  wire logic                  dirTglEn,          // direction_toggle_reg write strobe
    input  wire logic [PINS-1:0]       dirTglData,        // ones invert direction bits
    input  wire logic                  outWriteEn,        // output value write strobe
    input  wire logic [PINS-1:0]       outWriteData,      // output value bits
    input  wire logic [3*PINS-1:0]     pinMode,           // pin_config_reg driver field, 3 bits a pin
    input  wire logic [2*PINS-1:0]     senseSel,          // pin_config_reg sense field, 2 bits a pin
    input  wire logic [PINS-1:0]       invertIo,          // pin_config_reg inversion bits
    input  wire logic [PINS-1:0]       inputDisable,      // digital input disabled per pin
    input  wire logic [PINS-1:0]       irqEnable,         // per-pin interrupt request mask
    input  wire logic [PINS-1:0]       eventEnable,       // per-pin event mask
    input  wire logic [PINS-1:0]       padIn,             // level seen on each pin
    output logic      [PINS-1:0]       padOut,            // level driven when enabled
    output logic      [PINS-1:0]       padOe,             // high while the port drives the pin
    output logic      [PINS-1:0]       pullUpEn,          // internal pull-up on
    output logic      [PINS-1:0]       pullDownEn,        // internal pull-down on
    output logic      [PINS-1:0]       pinDirection,      // direction register, also the rmw read value
    output logic      [PINS-1:0]       outValue,          // output value register
    output logic      [PINS-1:0]       inputValue,        // synchronised input value register
    output logic      [PINS-1:0]       interruptRequest,  // per-pin synchronous sense request
    output logic      [PINS-1:0]       senseEvent,        // per-pin synchronous sense event
    output logic      [PINS-1:0]       asyncWake          // clockless wake request per pin
);

    // apply whole write, then set, clear and toggle, so strobes never fight
    function automatic logic [PINS-1:0] dirNext(
        input logic [PINS-1:0] cur,
        input logic            wEn, input logic [PINS-1:0] wDat,
        input logic            sEn, input logic [PINS-1:0] sDat,
        input logic            cEn, input logic [PINS-1:0] cDat,
        input logic            tEn, input logic [PINS-1:0] tDat
    );
        logic [PINS-1:0] v;
        v = wEn ? wDat : cur;
        v = sEn ? (v | sDat) : v;
        v = cEn ? (v & ~cDat) : v;
        v = tEn ? (v ^ tDat) : v;
        return v;
    endfunction : dirNext

    // state registers
    logic [PINS-1:0] syncStage;      // first synchroniser flip-flop
    logic [PINS-1:0] prevValue;      // input value one clock earlier
    logic [PINS-1:0] keepLevel;      // last level seen, for the keeper

    // decoded per-pin control
    logic [PINS-1:0] isWiredOr;      // wired-or driver selected
    logic [PINS-1:0] isWiredAnd;     // wired-and driver selected
    logic [PINS-1:0] pushUp;         // push-pull pull-up requested
    logic [PINS-1:0] pushDown;       // push-pull pull-down requested
    logic [PINS-1:0] keeperOn;       // bus-keeper selected
    logic [PINS-1:0] wiredUp;        // wired-and pull-up requested
    logic [PINS-1:0] wiredDown;      // wired-or pull-down requested
    logic [PINS-1:0] driveLevel;     // output value after inversion
    logic [PINS-1:0] rawOe;          // enable before reset gating
    logic [PINS-1:0] rawOut;         // level before reset gating
    logic [PINS-1:0] rawUp;          // pull-up before reset gating
    logic [PINS-1:0] rawDown;        // pull-down before reset gating
    logic [PINS-1:0] riseSeen;       // synchronous rising edge
    logic [PINS-1:0] fallSeen;       // synchronous falling edge
    logic [PINS-1:0] senseHit;       // selected irq condition met
    logic [PINS-1:0] eventHit;       // selected event condition met
    logic [PINS-1:0] nextDir;        // direction after this cycle's writes
    logic [PINS-1:0] pushPull;       // neither wired mode selected

    assign nextDir = dirNext(pinDirection, dirWriteEn, dirWriteData,
                             dirSetEn, dirSetData, dirClrEn, dirClrData,
                             dirTglEn, dirTglData);

    // per-pin decode of the configuration fields
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            wire logic [2:0] modeBits  = pinMode[3*gi +: 3];
            wire logic [1:0] senseBits = senseSel[2*gi +: 2];
            assign isWiredOr[gi]  = (modeBits == gpio_pkg::GPIO_WIREDOR)
                                  | (modeBits == gpio_pkg::GPIO_WIREDOR_PD);
            assign isWiredAnd[gi] = (modeBits == gpio_pkg::GPIO_WIREDAND)
                                  | (modeBits == gpio_pkg::GPIO_WIREDAND_PU);
            assign pushUp[gi]     = (modeBits == gpio_pkg::GPIO_PULLUP);
            assign pushDown[gi]   = (modeBits == gpio_pkg::GPIO_PULLDOWN);
            assign keeperOn[gi]   = (modeBits == gpio_pkg::GPIO_BUSKEEPER);
            assign wiredUp[gi]    = (modeBits == gpio_pkg::GPIO_WIREDAND_PU);
            assign wiredDown[gi]  = (modeBits == gpio_pkg::GPIO_WIREDOR_PD);
            // sense selection, edges and level from the synced value
            assign senseHit[gi] =
                (senseBits == gpio_pkg::GPIO_SENSE_BOTH) ? (riseSeen[gi] | fallSeen[gi]) :
                (senseBits == gpio_pkg::GPIO_SENSE_RISE) ? riseSeen[gi] :
                (senseBits == gpio_pkg::GPIO_SENSE_FALL) ? fallSeen[gi] :
                ~inputValue[gi];
            // events follow the high level for level sense
            assign eventHit[gi] =
                (senseBits == gpio_pkg::GPIO_SENSE_LOW) ? inputValue[gi] : senseHit[gi];
            // clockless wake: low level, or any change from the held value
            assign asyncWake[gi] = ~reset & irqEnable[gi] & (
                (senseBits == gpio_pkg::GPIO_SENSE_LOW)
                    ? ~(padIn[gi] ^ invertIo[gi])
                    : ((padIn[gi] ^ invertIo[gi]) != inputValue[gi]));
        end
    endgenerate

    // output path with optional inversion
    assign driveLevel = outValue ^ invertIo;

    // per-pin driver kind, selected bit by bit so each pin takes its own mode
    assign pushPull = ~(isWiredOr | isWiredAnd);

    // driver: push-pull follows direction, wired modes drive one level only
    assign rawOe  = (isWiredOr  & pinDirection & driveLevel)
                  | (isWiredAnd & pinDirection & ~driveLevel)
                  | (pushPull   & pinDirection);
    assign rawOut = isWiredOr                                            // wired-or drives high
                  | (pushPull & driveLevel);

    // pulls: push-pull only on input, wired and keeper in both directions
    assign rawUp   = (pushUp & ~pinDirection) | wiredUp
                   | (keeperOn & keepLevel);
    assign rawDown = (pushDown & ~pinDirection) | wiredDown
                   | (keeperOn & ~keepLevel);

    // reset gates the pad outputs without needing a clock edge
    assign padOe      = reset ? {PINS{1'b0}} : rawOe;
    assign padOut     = reset ? {PINS{1'b0}} : rawOut;
    assign pullUpEn   = reset ? {PINS{1'b0}} : rawUp;
    assign pullDownEn = reset ? {PINS{1'b0}} : rawDown;

    // edges from the current and previous synchronised value
    assign riseSeen = inputValue & ~prevValue;
    assign fallSeen = ~inputValue & prevValue;

    // direction and output value registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinDirection <= gpio_pkg::DIR_RESET;
            outValue     <= gpio_pkg::OUT_RESET;
        end else begin
            pinDirection <= nextDir;
            if (outWriteEn) begin
                outValue <= outWriteData;
            end
        end
    end

    // input synchroniser: one flip-flop, then the input value register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            syncStage  <= gpio_pkg::IN_RESET;
            inputValue <= gpio_pkg::IN_RESET;
            prevValue  <= gpio_pkg::IN_RESET;
        end else begin
            syncStage  <= (padIn ^ invertIo) & ~inputDisable;
            inputValue <= syncStage;
            prevValue  <= inputValue;
        end
    end

    // keeper level and registered sense outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            keepLevel        <= {PINS{1'b0}};
            interruptRequest <= {PINS{1'b0}};
            senseEvent       <= {PINS{1'b0}};
        end else begin
            keepLevel        <= inputValue ^ invertIo;
            interruptRequest <= senseHit & irqEnable;
            senseEvent       <= eventHit & eventEnable;
        end
    end

    // checks on the core clock, all but pads_tristate_reset_a quiet under reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    pads_tristate_reset_a: assert property (
        @(posedge core_clk) disable iff (1'b0)
        reset |-> (padOe == '0 && pullUpEn == '0 && pullDownEn == '0))
        else $error("pads not released under reset");

    dir_set_bits_a: assert property (
        (dirSetEn && !dirWriteEn && !dirClrEn && !dirTglEn)
            |=> pinDirection == ($past(pinDirection) | $past(dirSetData)))
        else $error("direction set wrong");

    dir_clear_bits_a: assert property (
        (dirClrEn && !dirWriteEn && !dirSetEn && !dirTglEn)
            |=> pinDirection == ($past(pinDirection) & ~$past(dirClrData)))
        else $error("direction clear wrong");

    dir_toggle_bits_a: assert property (
        (dirTglEn && !dirWriteEn && !dirSetEn && !dirClrEn)
            |=> pinDirection == ($past(pinDirection) ^ $past(dirTglData)))
        else $error("direction toggle wrong");

    sync_two_stage_a: assert property (
        (invertIo == '0 && inputDisable == '0) [*3]
            |-> inputValue == $past(padIn, 2))
        else $error("input not two clocks behind pin");

    pushpull_drive_a: assert property (
        (!isWiredOr[0] && !isWiredAnd[0] && pinDirection[0] && !invertIo[0])
            |-> (padOe[0] && padOut[0] == outValue[0]))
        else $error("push-pull pin not driving output value");

    wired_release_a: assert property (
        (isWiredOr[0] && !invertIo[0] && !outValue[0]) |-> !padOe[0])
        else $error("wired-or pin driven while value zero");

    wiredand_drive_a: assert property (
        (isWiredAnd[0] && !invertIo[0] && pinDirection[0])
            |-> (padOe[0] == !outValue[0] && padOut[0] == 1'b0))
        else $error("wired-and drive wrong");

    pull_input_only_a: assert property (
        (pushUp[0] && pinDirection[0]) |-> !pullUpEn[0])
        else $error("push-pull pull-up on while output");

    rise_irq_timing_a: assert property (
        (irqEnable[0] && senseSel[1:0] == gpio_pkg::GPIO_SENSE_RISE
            && inputValue[0] && !prevValue[0])
            |=> interruptRequest[0])
        else $error("rising edge request missing");

    no_early_irq_a: assert property (
        (senseSel[1:0] == gpio_pkg::GPIO_SENSE_RISE && inputValue[0] == prevValue[0])
            |=> !interruptRequest[0])
        else $error("edge request without sampled change");

    keeper_level_a: assert property (
        keeperOn[0] [*2]
            |-> pullUpEn[0] == $past(inputValue[0] ^ invertIo[0]))
        else $error("keeper not holding last level");

    keeper_both_a: assert property (
        (keeperOn[0] && pinDirection[0])
            |-> (pullUpEn[0] || pullDownEn[0]))
        else $error("keeper off while output");

    wired_pullup_a: assert property (
        wiredUp[0]
            |-> pullUpEn[0])
        else $error("wired pull-up not active");

    wired_pulldown_a: assert property (
        wiredDown[0]
            |-> pullDownEn[0])
        else $error("wired pull-down not active");

    wiredor_drive_a: assert property (
        (isWiredOr[0] && !invertIo[0] && pinDirection[0] && outValue[0])
            |-> (padOe[0] && padOut[0]))
        else $error("wired-or pin not driven high");

    input_float_a: assert property (
        (pushPull[0] && !keeperOn[0] && !pushUp[0] && !pushDown[0] && !pinDirection[0])
            |-> !(padOe[0] || pullUpEn[0] || pullDownEn[0]))
        else $error("plain input pin not floating");

    pulldown_input_a: assert property (
        (pushDown[0] && pinDirection[0])
            |-> !pullDownEn[0])
        else $error("push-pull pull-down on while output");

    input_disabled_a: assert property (
        inputDisable[0] [*3]
            |-> !inputValue[0])
        else $error("disabled input still read");

    dir_write_a: assert property (
        (dirWriteEn && !dirSetEn && !dirClrEn && !dirTglEn)
            |=> pinDirection == $past(dirWriteData))
        else $error("direction write wrong");

    out_write_a: assert property (
        outWriteEn
            |=> outValue == $past(outWriteData))
        else $error("output value write wrong");

    invert_output_a: assert property (
        (pushPull[0] && pinDirection[0])
            |-> padOut[0] == (outValue[0] ^ invertIo[0]))
        else $error("output inversion wrong");

    fall_irq_a: assert property (
        (irqEnable[0] && senseSel[1:0] == gpio_pkg::GPIO_SENSE_FALL
            && !inputValue[0] && prevValue[0]) |=> interruptRequest[0])
        else $error("falling edge request missing");

    level_irq_a: assert property (
        (irqEnable[0] && senseSel[1:0] == gpio_pkg::GPIO_SENSE_LOW && !inputValue[0])
            |=> interruptRequest[0])
        else $error("low level request missing");

    level_event_a: assert property (
        (eventEnable[0] && senseSel[1:0] == gpio_pkg::GPIO_SENSE_LOW && inputValue[0])
            |=> senseEvent[0])
        else $error("high level event missing");

    async_low_wake_a: assert property (
        (irqEnable[0] && senseSel[1:0] == gpio_pkg::GPIO_SENSE_LOW
            && !(padIn[0] ^ invertIo[0])) |-> asyncWake[0])
        else $error("low level wake missing");

    dir_hold_a: assert property (
        !(dirWriteEn || dirSetEn || dirClrEn || dirTglEn)
            |=> $stable(pinDirection))
        else $error("direction changed without a write");

endmodule : gpio_port

// File: gpio_pkg.sv
// gpio_pkg: constants shared by the general purpose port logic
// assumes a single core clock domain and plain-port configuration
package gpio_pkg;

    // pin count and field widths
    localparam int PIN_COUNT     = 8;
    localparam int MODE_W        = 3;
    localparam int SENSE_W       = 2;

    // output driver and pull configuration held per pin
    typedef enum logic [2:0] {
        GPIO_TOTEM         = 3'h0,  // push-pull, no pull
        GPIO_BUSKEEPER     = 3'h1,  // push-pull with keeper
        GPIO_PULLDOWN      = 3'h2,  // push-pull, pull-down on input
        GPIO_PULLUP        = 3'h3,  // push-pull, pull-up on input
        GPIO_WIREDOR       = 3'h4,  // wired-or, no pull
        GPIO_WIREDAND      = 3'h5,  // wired-and, no pull
        GPIO_WIREDOR_PD    = 3'h6,  // wired-or with pull-down
        GPIO_WIREDAND_PU   = 3'h7   // wired-and with pull-up
    } gpio_mode_e;

    // input sense selection held per pin
    typedef enum logic [1:0] {
        GPIO_SENSE_BOTH    = 2'h0,  // any edge
        GPIO_SENSE_RISE    = 2'h1,  // rising edge
        GPIO_SENSE_FALL    = 2'h2,  // falling edge
        GPIO_SENSE_LOW     = 2'h3   // low level
    } gpio_sense_e;

    // reset values of the software-visible state
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'h00;
    localparam logic [7:0] IN_RESET  = 8'h00;

    // stages between the pin and the input value register
    localparam int SYNC_STAGES = 2;

endpackage : gpio_pkg

// File: gpio_pad_model.sv
// gpio_pad_model: external circuitry on the port pins, resolves each wire
// assumes pad controls come straight from the port and the bench can drive pins
`timescale 1ns/100ps
module gpio_pad_model (
    input  wire logic       core_clk,   // peripheral clock, paces the float pattern
    input  wire logic [7:0] padOut,     // level the port drives
    input  wire logic [7:0] padOe,      // high while the port drives
    input  wire logic [7:0] pullUpEn,   // internal pull-up on
    input  wire logic [7:0] pullDownEn, // internal pull-down on
    input  wire logic [7:0] extEn,      // outside driver active
    input  wire logic [7:0] extValue,   // outside driver level
    output logic      [7:0] padIn       // resolved wire level
);
    logic [7:0] lastLvl = 8'h00;        // previous wire level, for floating pins

    // port driver first, then outside driver, then pulls, else a toggling float
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (extEn[i]) padIn[i] = extValue[i];
            else if (pullUpEn[i]) padIn[i] = 1'b1;
            else if (pullDownEn[i]) padIn[i] = 1'b0;
            else padIn[i] = ~lastLvl[i];
        end
    end

    // remember the wire so a floating pin changes every cycle
    always @(posedge core_clk) begin
        lastLvl <= padIn;
    end
endmodule : gpio_pad_model

// File: test_general_purpose_io_port.sv
// test_general_purpose_io_port: self-checking bench for the port
// assumes gpio_pkg, gpio_port and gpio_pad_model are compiled first
`timescale 1ns/100ps
module test_general_purpose_io_port;
    logic core_clk = 1'b0, reset = 1'b1;               // clock and reset
    logic dirWriteEn = 0, dirSetEn = 0, dirClrEn = 0;  // direction strobes
    logic dirTglEn = 0, outWriteEn = 0;                // toggle and output strobes
    logic [7:0] dirWriteData = 0, dirSetData = 0, dirClrData = 0, dirTglData = 0;
    logic [7:0] outWriteData = 0, invertIo = 0, inputDisable = 0;
    logic [7:0] irqEnable = 8'hFF, eventEnable = 8'hFF, extEn = 0, extValue = 0;
    logic [23:0] pinMode = 0;                          // driver field per pin
    logic [15:0] senseSel = 0;                         // sense field per pin
    logic [7:0] padIn, padOut, padOe, pullUpEn, pullDownEn, pinDirection;
    logic [7:0] outValue, inputValue, interruptRequest, senseEvent, asyncWake;
    int nFail = 0, samplesChecked = 0;                 // mismatch and compare counts

    gpio_port gpio_port_inst (.core_clk(core_clk), .reset(reset),
        .dirWriteEn(dirWriteEn), .dirWriteData(dirWriteData), .dirSetEn(dirSetEn),
        .dirSetData(dirSetData), .dirClrEn(dirClrEn), .dirClrData(dirClrData),
        .dirTglEn(dirTglEn), .dirTglData(dirTglData), .outWriteEn(outWriteEn),
        .outWriteData(outWriteData), .pinMode(pinMode), .senseSel(senseSel),
        .invertIo(invertIo), .inputDisable(inputDisable), .irqEnable(irqEnable),
        .eventEnable(eventEnable), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .pinDirection(pinDirection),
        .outValue(outValue), .inputValue(inputValue),
        .interruptRequest(interruptRequest), .senseEvent(senseEvent),
        .asyncWake(asyncWake));
    gpio_pad_model gpio_pad_model_inst (.core_clk(core_clk), .padOut(padOut),
        .padOe(padOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extEn(extEn),
        .extValue(extValue), .padIn(padIn));

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    // compare one value and report a difference
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h wanted %h", $time, seen, exp);
        end
    endtask : check

    // one strobed write: 0 whole dir, 1 set, 2 clear, 3 toggle, 4 output
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge core_clk);
        case (k)
            0: begin dirWriteEn <= 1; dirWriteData <= d; end
            1: begin dirSetEn <= 1; dirSetData <= d; end
            2: begin dirClrEn <= 1; dirClrData <= d; end
            3: begin dirTglEn <= 1; dirTglData <= d; end
            default: begin outWriteEn <= 1; outWriteData <= d; end
        endcase
        @(posedge core_clk);
        {dirWriteEn, dirSetEn, dirClrEn, dirTglEn, outWriteEn} <= 5'h00;
        #1;
    endtask : wr

    // advance whole cycles and settle
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // print the verdict and stop
    task automatic giveVerdict;
        if (nFail == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : giveVerdict

    // main sequence
    initial begin
        #1 check(padOe | pullUpEn | pullDownEn, 8'h00);
        tick(10);
        reset <= 1'b0;
        check(pinDirection, 8'h00);
        wr(0, 8'hA5); check(pinDirection, 8'hA5);
        wr(1, 8'h0F); check(pinDirection, 8'hAF);
        wr(2, 8'h81); check(pinDirection, 8'h2E);
        wr(3, 8'hFF); check(pinDirection, 8'hD1);
        wr(3, 8'h02); check(pinDirection, 8'hD3);
        // push-pull drive and output inversion
        wr(0, 8'hFF); wr(4, 8'h3C);
        check(padOe, 8'hFF); check(padOut, 8'h3C);
        check(outValue, 8'h3C);
        @(posedge core_clk) invertIo <= 8'hFF; tick(1);
        check(padOut, 8'hC3);
        @(posedge core_clk) invertIo <= 8'h00; reset <= 1'b1; #1;
        check(padOe, 8'h00);
        tick(1); reset <= 1'b0;
        // pulls in push-pull and wired modes
        @(posedge core_clk) pinMode <= {8{3'h3}};
        wr(0, 8'h0F);
        check(pullUpEn, 8'hF0); check(padOe, 8'h0F);
        @(posedge core_clk) pinMode <= {8{3'h7}}; tick(1);
        check(pullUpEn, 8'hFF);
        @(posedge core_clk) pinMode <= {8{3'h6}}; tick(1);
        check(pullDownEn, 8'hFF);
        // wired-or and wired-and drive
        wr(0, 8'hFF); wr(4, 8'h55);
        @(posedge core_clk) pinMode <= {8{3'h4}}; tick(1);
        check(padOe, 8'h55); check(padOut & padOe, 8'h55);
        @(posedge core_clk) pinMode <= {8{3'h5}}; tick(1);
        check(padOe, 8'hAA); check(padOut & padOe, 8'h00);
        // input synchroniser and rising-edge sense on pin 0
        @(posedge core_clk) pinMode <= 24'h000000;
        senseSel <= {8{2'h1}}; inputDisable <= 8'hFE; extEn <= 8'h01;
        wr(0, 8'h00); tick(4);
        check(padOe | pullUpEn | pullDownEn, 8'h00);
        @(posedge core_clk) extValue <= 8'h01; #1;
        check(asyncWake & 8'h01, 8'h01);
        tick(1); check(inputValue, 8'h00);
        tick(1); check(inputValue, 8'h01);
        check(asyncWake & 8'h01, 8'h00);
        tick(1); check(interruptRequest, 8'h01);
        check(senseEvent, 8'h01);
        tick(1); check(interruptRequest, 8'h00);
        // falling sense then low level on pin 0
        @(posedge core_clk) senseSel <= {8{2'h2}}; extValue <= 8'h00;
        tick(3); check(interruptRequest, 8'h01);
        @(posedge core_clk) senseSel <= {8{2'h3}}; irqEnable <= 8'h01;
        tick(3); check(interruptRequest, 8'h01);
        tick(2); check(interruptRequest, 8'h01);
        @(posedge core_clk) extValue <= 8'h01;
        tick(3); check(interruptRequest, 8'h00);
        check(senseEvent, 8'h01);
        // keeper on pin 0 follows the held high level
        @(posedge core_clk) pinMode <= {8{3'h1}};
        tick(2); check(pullUpEn & 8'h01, 8'h01);
        giveVerdict();
    end

    // cut a hang short
    initial begin
        repeat (400) @(posedge core_clk);
        nFail++;
        giveVerdict();
    end
endmodule : test_general_purpose_io_port
